// file: rtl/dcsp_top.sv
// dual channel codec serial port with AHB-Lite register slave
// assumes clk_sys at 10 MHz; pins are async and synchronised here
// What this block does
// - user flag pin follows control bit 10
// - quarter rate clock output from oscillator
// - two receive inputs, own receive registers
// - transmit lines shift out, else high impedance
// - internal sync pulse starts both directions
// - short or long internal sync pulse
// - sync rate is bit clock over divider plus one
// - receive sync falling edge starts receive
// - receive sync rising edge sets done flag
// - transmit sync falling edge starts transmit
// - transmit sync rising edge sets done flag
// - bit clock pin input or output
// - output bit clock divided from oscillator
// - reset floats bit clock pin
// - reset floats transmit lines
// - eight bit sample registers, port mapped
// - port one data, port zero control
//
// Local design decisions: register access over AHB-Lite and the register offsets.
`default_nettype none
module dcsp_top
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic osc_input,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic hsel,
   input wire logic hready,
   input wire logic [31:0] hwdata,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic rx_line_0,
   input wire logic rx_line_1,
   output logic tx_line_0_o,
   output logic tx_line_0_oe,
   output logic tx_line_1_o,
   output logic tx_line_1_oe,
   input wire logic rx_sync_in_n,
   input wire logic tx_sync_in_n,
   input wire logic sclk_i,
   output logic sclk_o,
   output logic sclk_oe,
   output logic internal_sync_pulse,
   output logic user_flag_pin,
   output logic quarter_rate_clock_out,
   output logic irq
);
   // ==========================================
   // two flop synchronisers
   function automatic logic edge_rise(input logic prev, input logic cur);
      edge_rise = cur & ~prev;
   endfunction : edge_rise

   logic [5:0] s1_r;
   logic [5:0] s2_r;
   logic [5:0] s3_r;
   // pins cross into clk_sys through two flops
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         s1_r <= 6'h3f;
         s2_r <= 6'h3f;
         s3_r <= 6'h3f;
      end
      else
      begin
         s1_r <= {osc_input, sclk_i, tx_sync_in_n, rx_sync_in_n, rx_line_1, rx_line_0};
         s2_r <= s1_r;
         s3_r <= s2_r;
      end
   end
   logic osc_rise;
   logic sclk_in_rise;
   logic fsx_fall;
   logic fsx_rise;
   logic fsr_fall;
   logic fsr_rise;
   assign osc_rise = edge_rise(s3_r[5], s2_r[5]);
   assign sclk_in_rise = edge_rise(s3_r[4], s2_r[4]);
   assign fsx_fall = edge_rise(s2_r[3], s3_r[3]);
   assign fsx_rise = edge_rise(s3_r[3], s2_r[3]);
   assign fsr_fall = edge_rise(s2_r[2], s3_r[2]);
   assign fsr_rise = edge_rise(s3_r[2], s2_r[2]);

   // ==========================================
   // control register and bus slave
   logic [31:0] ctrl_r;
   logic [7:0] tx0_r;
   logic [7:0] tx1_r;
   logic [7:0] rx0_r;
   logic [7:0] rx1_r;
   logic wr_ph_r;
   logic [7:0] addr_ph_r;
   logic rx_set;
   logic tx_set;
   logic acc;
   logic busy0;
   logic busy1;
   logic ext_frame;
   assign acc = hsel & hready & htrans[1];
   assign ext_frame = ctrl_r[dcsp_pkg::EXT_FRAME_BIT];

   // capture address phase
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         wr_ph_r <= 1'b0;
         addr_ph_r <= 8'h00;
      end
      else
      begin
         wr_ph_r <= acc & hwrite;
         if (acc)
            addr_ph_r <= haddr[7:0];
      end
   end

   // control writes; hardware set of done flags wins over clear
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
         ctrl_r <= dcsp_pkg::CTRL_RESET;
      else
      begin
         if (wr_ph_r && addr_ph_r == dcsp_pkg::CTRL_OFF)
            ctrl_r <= (hwdata & dcsp_pkg::CTRL_WMASK) | (ctrl_r & ~dcsp_pkg::CTRL_WMASK
                      & {29'h0, ~hwdata[2:1], 1'b1});
         if (rx_set)
            ctrl_r[dcsp_pkg::RX_DONE_BIT] <= 1'b1;
         if (tx_set)
            ctrl_r[dcsp_pkg::TX_DONE_BIT] <= 1'b1;
      end
   end

   // transmit samples, port one data register
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         tx0_r <= 8'h00;
         tx1_r <= 8'h00;
      end
      else if (wr_ph_r && addr_ph_r == dcsp_pkg::DATA_OFF)
      begin
         tx0_r <= hwdata[7:0];
         tx1_r <= hwdata[15:8];
      end
   end

   // read mux, registered on the address phase
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
         hrdata <= 32'h0000_0000;
      else if (acc && !hwrite)
      begin
         case (haddr[7:0])
            dcsp_pkg::CTRL_OFF: hrdata <= ctrl_r;
            dcsp_pkg::DATA_OFF: hrdata <= {rx1_r, rx0_r, tx1_r, tx0_r};
            dcsp_pkg::STAT_OFF: hrdata <= {30'h0, busy1, busy0};
            default: hrdata <= 32'h0000_0000;
         endcase
      end
   end
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;

   // ==========================================
   // clock dividers
   logic [1:0] quarter_r;
   logic [3:0] bdiv_r;
   logic sclk_r;
   logic sclk_out_rise;
   // quarter rate system clock from oscillator
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
         quarter_r <= 2'h0;
      else if (osc_rise)
         quarter_r <= quarter_r + 2'h1;
   end
   assign quarter_rate_clock_out = quarter_r[1];

   // bit clock out: toggles every divider+1 rising oscillator edges
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         bdiv_r <= 4'h0;
         sclk_r <= 1'b0;
      end
      else if (osc_rise)
      begin
         if (bdiv_r >= ctrl_r[dcsp_pkg::BCLK_DIV_LSB +: 4])
         begin
            bdiv_r <= 4'h0;
            sclk_r <= ~sclk_r;
         end
         else
            bdiv_r <= bdiv_r + 4'h1;
      end
   end
   assign sclk_out_rise = osc_rise && !sclk_r && bdiv_r >= ctrl_r[dcsp_pkg::BCLK_DIV_LSB +: 4];
   assign sclk_o = sclk_r;
   assign sclk_oe = ctrl_r[dcsp_pkg::CLK_OUT_BIT] & ~rst;

   logic bit_tick;
   // pick bit clock source; input mode relies on a running clock
   assign bit_tick = ctrl_r[dcsp_pkg::CLK_OUT_BIT] ? sclk_out_rise : sclk_in_rise;

   // ==========================================
   // internal sync generator
   logic [7:0] fdiv_r;
   logic [3:0] fr_len_r;
   logic fr_r;
   logic fr_start;
   // one frame every divider+1 bit clocks
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
         fdiv_r <= 8'h00;
      else if (bit_tick && !ext_frame)
         fdiv_r <= (fdiv_r >= ctrl_r[dcsp_pkg::SYNC_DIV_LSB +: 8]) ? 8'h00 : fdiv_r + 8'h01;
   end
   assign fr_start = bit_tick && !ext_frame && fdiv_r == 8'h00;

   // short pulse one bit, long pulse eight bits
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         fr_r <= 1'b0;
         fr_len_r <= 4'h0;
      end
      else if (fr_start)
      begin
         fr_r <= 1'b1;
         fr_len_r <= ctrl_r[dcsp_pkg::LONG_SYNC_BIT] ? dcsp_pkg::BIT_COUNT_LAST - 4'h1 : 4'h0;
      end
      else if (bit_tick && fr_r)
      begin
         if (fr_len_r == 4'h0)
            fr_r <= 1'b0;
         else
            fr_len_r <= fr_len_r - 4'h1;
      end
   end
   assign internal_sync_pulse = fr_r;

   // ==========================================
   // channel engines
   logic rx_go;
   logic tx_go;
   logic txb0;
   logic txb1;
   logic tx_act_r;
   assign rx_go = ext_frame ? fsr_fall : fr_start;
   assign tx_go = ext_frame ? fsx_fall : fr_start;
   assign rx_set = ext_frame & fsr_rise;
   assign tx_set = ext_frame & fsx_rise;

   dcsp_shift_if rxa0();
   dcsp_shift_if rxa1();
   dcsp_shift_if txa0();
   dcsp_shift_if txa1();
   assign rxa0.bit_tick = bit_tick;
   assign rxa1.bit_tick = bit_tick;
   assign txa0.bit_tick = bit_tick;
   assign txa1.bit_tick = bit_tick;
   assign rxa0.start = rx_go;
   assign rxa1.start = rx_go;
   assign txa0.start = tx_go;
   assign txa1.start = tx_go;
   assign rxa0.tx_data = 8'h00;
   assign rxa1.tx_data = 8'h00;
   assign txa0.tx_data = tx0_r;
   assign txa1.tx_data = tx1_r;
   assign rxa0.rx_bit = s3_r[0];
   assign rxa1.rx_bit = s3_r[1];
   assign txa0.rx_bit = 1'b0;
   assign txa1.rx_bit = 1'b0;
   assign busy0 = rxa0.busy | txa0.busy;
   assign busy1 = rxa1.busy | txa1.busy;
   assign txb0 = txa0.tx_bit;
   assign txb1 = txa1.tx_bit;

   dcsp_shifter u_rx0 (.clk_sys(clk_sys), .rst(rst), .sif(rxa0));
   dcsp_shifter u_rx1 (.clk_sys(clk_sys), .rst(rst), .sif(rxa1));
   dcsp_shifter u_tx0 (.clk_sys(clk_sys), .rst(rst), .sif(txa0));
   dcsp_shifter u_tx1 (.clk_sys(clk_sys), .rst(rst), .sif(txa1));

   // receive registers load when a frame completes
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         rx0_r <= 8'h00;
         rx1_r <= 8'h00;
      end
      else
      begin
         if (rxa0.done)
            rx0_r <= rxa0.rx_data;
         if (rxa1.done)
            rx1_r <= rxa1.rx_data;
      end
   end

   // transmit enable register follows the transmit engine
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
         tx_act_r <= 1'b0;
      else
         tx_act_r <= txa0.busy;
   end
   assign tx_line_0_o = txb0;
   assign tx_line_1_o = txb1;
   assign tx_line_0_oe = tx_act_r & txa0.busy & ~rst;
   assign tx_line_1_oe = tx_act_r & txa1.busy & ~rst;

   assign user_flag_pin = ctrl_r[dcsp_pkg::USER_FLAG_BIT];
   assign irq = (ctrl_r[dcsp_pkg::RX_DONE_BIT] & ctrl_r[dcsp_pkg::RX_IE_BIT])
              | (ctrl_r[dcsp_pkg::TX_DONE_BIT] & ctrl_r[dcsp_pkg::TX_IE_BIT]);

   // ==========================================
   // checks
   a_flag_pin: assert property (@(posedge clk_sys) disable iff (rst)
      user_flag_pin == ctrl_r[dcsp_pkg::USER_FLAG_BIT])
      else $error("flag pin differs from control bit");
   a_rx_flag: assert property (@(posedge clk_sys) disable iff (rst)
      rx_set |=> ctrl_r[dcsp_pkg::RX_DONE_BIT])
      else $error("receive done flag not set");
   a_tx_flag: assert property (@(posedge clk_sys) disable iff (rst)
      tx_set |=> ctrl_r[dcsp_pkg::TX_DONE_BIT])
      else $error("transmit done flag not set");
   a_tx_float: assert property (@(posedge clk_sys) disable iff (rst)
      !txa0.busy |-> !tx_line_0_oe)
      else $error("transmit line driven while idle");
   a_rx_start: assert property (@(posedge clk_sys) disable iff (rst)
      (ext_frame && fsr_fall && !rxa0.busy) |=> rxa0.busy)
      else $error("receive did not start on sync fall");
   a_tx_start: assert property (@(posedge clk_sys) disable iff (rst)
      (ext_frame && fsx_fall && !txa0.busy) |=> txa0.busy)
      else $error("transmit did not start on sync fall");
   a_sync_start: assert property (@(posedge clk_sys) disable iff (rst)
      fr_start |=> internal_sync_pulse)
      else $error("sync pulse not raised at frame start");
   a_sclk_dir: assert property (@(posedge clk_sys) disable iff (rst)
      sclk_oe == ctrl_r[dcsp_pkg::CLK_OUT_BIT])
      else $error("bit clock direction wrong");
   c_ext_rx: cover property (@(posedge clk_sys) disable iff (rst) rxa0.done && ext_frame);
   c_int_frame: cover property (@(posedge clk_sys) disable iff (rst) fr_start);
   c_irq: cover property (@(posedge clk_sys) disable iff (rst) irq);
endmodule : dcsp_top
`default_nettype wire

// file: rtl/dcsp_pkg.sv
// package for the dual channel codec serial port
// assumes one 10 MHz system clock and an AHB-Lite register slave
`default_nettype none
package dcsp_pkg;
   // register byte offsets
   localparam logic [7:0] CTRL_OFF = 8'h00;
   localparam logic [7:0] DATA_OFF = 8'h04;
   localparam logic [7:0] STAT_OFF = 8'h08;
   // control register field positions
   localparam int RX_DONE_BIT = 1;
   localparam int TX_DONE_BIT = 2;
   localparam int RX_IE_BIT = 3;
   localparam int TX_IE_BIT = 4;
   localparam int EXT_FRAME_BIT = 5;
   localparam int LONG_SYNC_BIT = 6;
   localparam int CLK_OUT_BIT = 7;
   localparam int USER_FLAG_BIT = 10;
   localparam int SYNC_DIV_LSB = 16;
   localparam int BCLK_DIV_LSB = 24;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
   localparam logic [31:0] CTRL_WMASK = 32'h0fff_fff9;
   localparam int SAMPLE_BITS = 8;
   localparam logic [3:0] BIT_COUNT_LAST = 4'h8;
   localparam logic [1:0] QUARTER_LAST = 2'h3;
   typedef enum logic [1:0]
   {
      SH_IDLE = 2'b00,
      SH_RUN = 2'b01,
      SH_DONE = 2'b10
   } dcsp_shift_state_type;
endpackage : dcsp_pkg
`default_nettype wire

// file: rtl/dcsp_shift_if.sv
// interface joining the control core and the shift engine
// assumes both ends share clk_sys
`default_nettype none
interface dcsp_shift_if;
   logic bit_tick;
   logic start;
   logic [7:0] tx_data;
   logic rx_bit;
   logic [7:0] rx_data;
   logic busy;
   logic tx_bit;
   logic done;
   modport core (output bit_tick, output start, output tx_data, output rx_bit,
                 input rx_data, input busy, input tx_bit, input done);
   modport eng (input bit_tick, input start, input tx_data, input rx_bit,
                output rx_data, output busy, output tx_bit, output done);
endinterface : dcsp_shift_if
`default_nettype wire

// file: rtl/dcsp_shifter.sv
// one serial channel shift engine, msb first, eight bits
// assumes bit_tick is a one cycle pulse per bit period
`default_nettype none
module dcsp_shifter
(
   input wire logic clk_sys,
   input wire logic rst,
   dcsp_shift_if.eng sif
);
   // ==========================================
   // shift state
   dcsp_pkg::dcsp_shift_state_type state_r;
   logic [7:0] tx_sh_r;
   logic [7:0] rx_sh_r;
   logic [3:0] cnt_r;
   logic done_r;

   // load on start, shift one bit per tick
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         state_r <= dcsp_pkg::SH_IDLE;
         tx_sh_r <= 8'h00;
         rx_sh_r <= 8'h00;
         cnt_r <= 4'h0;
         done_r <= 1'b0;
      end
      else
      begin
         done_r <= 1'b0;
         case (state_r)
            dcsp_pkg::SH_IDLE:
            begin
               if (sif.start)
               begin
                  tx_sh_r <= sif.tx_data;
                  cnt_r <= 4'h0;
                  state_r <= dcsp_pkg::SH_RUN;
               end
            end
            dcsp_pkg::SH_RUN:
            begin
               if (sif.bit_tick)
               begin
                  rx_sh_r <= {rx_sh_r[6:0], sif.rx_bit};
                  tx_sh_r <= {tx_sh_r[6:0], 1'b0};
                  cnt_r <= cnt_r + 4'h1;
                  if (cnt_r == dcsp_pkg::BIT_COUNT_LAST - 4'h1)
                     state_r <= dcsp_pkg::SH_DONE;
               end
            end
            dcsp_pkg::SH_DONE:
            begin
               done_r <= 1'b1;
               state_r <= dcsp_pkg::SH_IDLE;
            end
            default: state_r <= dcsp_pkg::SH_IDLE;
         endcase
      end
   end

   assign sif.busy = (state_r == dcsp_pkg::SH_RUN);
   assign sif.tx_bit = tx_sh_r[7]; // msb first
   assign sif.rx_data = rx_sh_r;
   assign sif.done = done_r;

   a_eight_bits: assert property (@(posedge clk_sys) disable iff (rst)
      sif.done |-> $past(cnt_r) == dcsp_pkg::BIT_COUNT_LAST)
      else $error("transfer ended without eight bits");
endmodule : dcsp_shifter
`default_nettype wire

// file: verif/dcsp_codec_model.sv
// codec model: free-running bit clock, active-low frame syncs, msb first
// assumes the bench resolves the bit clock and transmit wires
`default_nettype none
module dcsp_codec_model
(
   input wire logic tx_wire_0,
   input wire logic tx_wire_1,
   output logic sclk_drv,
   output logic rx_line_0,
   output logic rx_line_1,
   output logic rx_sync_in_n,
   output logic tx_sync_in_n
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] got_0;
   logic [7:0] got_1;
   // ==========================================
   // idle levels and bit clock
   initial
   begin
      sclk_drv = 1'b0;
      rx_line_0 = 1'b0;
      rx_line_1 = 1'b0;
      rx_sync_in_n = 1'b1;
      tx_sync_in_n = 1'b1;
   end
   // bit clock never stops, frames or not
   always #1600 sclk_drv = ~sclk_drv;
   // ==========================================
   // one frame: data changes on falling bit clock, taken on rising
   task automatic frame(input logic [7:0] d0, input logic [7:0] d1);
      int i;
      begin
         @(negedge sclk_drv);
         rx_sync_in_n = 1'b0;
         tx_sync_in_n = 1'b0;
         for (i = 7; i >= 0; i--)
         begin
            rx_line_0 = d0[i];
            rx_line_1 = d1[i];
            @(posedge sclk_drv);
            got_0[i] = tx_wire_0;
            got_1[i] = tx_wire_1;
            @(negedge sclk_drv);
         end
         rx_sync_in_n = 1'b1;
         tx_sync_in_n = 1'b1;
         rx_line_0 = ~rx_line_0; // stale data would hide a late sample
         rx_line_1 = ~rx_line_1;
      end
   endtask : frame
endmodule : dcsp_codec_model
`default_nettype wire

// file: verif/dcsp_bench.sv
// bench for the codec serial port: AHB-Lite master, codec model, pin timing
// assumes a zero wait state slave, 10 MHz system clock, 1 MHz oscillator
`default_nettype none
module dcsp_bench;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [31:0] A_CTRL = {24'h00, dcsp_pkg::CTRL_OFF};
   localparam logic [31:0] A_DATA = {24'h00, dcsp_pkg::DATA_OFF};
   localparam logic [31:0] A_STAT = {24'h00, dcsp_pkg::STAT_OFF};
   logic clk_sys, rst, osc_input, hwrite, hsel, hreadyout, hresp, codec_clk_en, mon;
   logic [31:0] haddr, hwdata, hrdata, rd, ctrl;
   logic [1:0] htrans, mon_sel;
   logic [2:0] hsize;
   logic rx_line_0, rx_line_1, rx_sync_in_n, tx_sync_in_n, sclk_drv, irq;
   logic tx_line_0_o, tx_line_0_oe, tx_line_1_o, tx_line_1_oe, sclk_o, sclk_oe;
   logic internal_sync_pulse, user_flag_pin, quarter_rate_clock_out;
   wire tx_wire_0, tx_wire_1, sclk_wire;
   int n_mismatch, compares, cycles, hi, per, n;
   logic [7:0] tx0_t [2] = '{8'ha5, 8'h00};
   logic [7:0] tx1_t [2] = '{8'h3c, 8'hff};
   logic [7:0] rx0_t [2] = '{8'h96, 8'hff};
   logic [7:0] rx1_t [2] = '{8'h5b, 8'h00};
   logic ie_t [2] = '{1'b1, 1'b0};
   // ==========================================
   // pin resolution, clocks, monitor select
   assign tx_wire_0 = tx_line_0_oe ? tx_line_0_o : 1'bz;
   assign tx_wire_1 = tx_line_1_oe ? tx_line_1_o : 1'bz;
   assign sclk_wire = sclk_oe ? sclk_o : (codec_clk_en ? sclk_drv : ~sclk_o);
   always #50 clk_sys = ~clk_sys;
   always #500 osc_input = ~osc_input;
   always_comb
   begin
      case (mon_sel)
         2'd0: mon = quarter_rate_clock_out;
         2'd1: mon = sclk_o;
         2'd2: mon = internal_sync_pulse;
         default: mon = tx_line_0_oe & tx_line_1_oe;
      endcase
   end
   dcsp_top uut
   (
      .clk_sys(clk_sys), .rst(rst), .osc_input(osc_input), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hsel(hsel), .hready(hreadyout), .hwdata(hwdata),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .rx_line_0(rx_line_0),
      .rx_line_1(rx_line_1), .tx_line_0_o(tx_line_0_o), .tx_line_0_oe(tx_line_0_oe),
      .tx_line_1_o(tx_line_1_o), .tx_line_1_oe(tx_line_1_oe), .rx_sync_in_n(rx_sync_in_n),
      .tx_sync_in_n(tx_sync_in_n), .sclk_i(sclk_wire), .sclk_o(sclk_o), .sclk_oe(sclk_oe),
      .internal_sync_pulse(internal_sync_pulse), .user_flag_pin(user_flag_pin),
      .quarter_rate_clock_out(quarter_rate_clock_out), .irq(irq)
   );
   dcsp_codec_model codec
   (
      .tx_wire_0(tx_wire_0), .tx_wire_1(tx_wire_1), .sclk_drv(sclk_drv), .rx_line_0(rx_line_0),
      .rx_line_1(rx_line_1), .rx_sync_in_n(rx_sync_in_n), .tx_sync_in_n(tx_sync_in_n)
   );
   // ==========================================
   // shared tasks
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      begin
         compares++;
         if (seen !== exp)
         begin
            n_mismatch++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
         end
      end
   endtask : check
   task automatic final_report;
      begin
         $display("mismatches %0d, comparisons %0d", n_mismatch, compares);
         if (n_mismatch == 0 && compares > 0)
            $display("verification passed");
         else
            $display("verification failed");
         $finish;
      end
   endtask : final_report
   // single word transfer, address phase held until hready
   task automatic ahb(input logic wr, input logic [31:0] addr, input logic [31:0] wd);
      begin
         @(posedge clk_sys);
         haddr <= addr;
         htrans <= 2'b10;
         hwrite <= wr;
         do @(posedge clk_sys); while (hreadyout !== 1'b1);
         htrans <= 2'b00;
         hwdata <= wd;
         do @(posedge clk_sys); while (hreadyout !== 1'b1);
         rd = hrdata;
      end
   endtask : ahb
   // counts negedges until the monitored pin reaches lvl
   task automatic wait_lvl(input logic lvl, inout int cnt);
      begin
         n = 0;
         while (mon !== lvl && n < 3000)
         begin
            @(negedge clk_sys);
            n++;
         end
         cnt += n;
      end
   endtask : wait_lvl
   // high time and period of one full cycle of the monitored pin
   task automatic measure(input logic [1:0] sel);
      begin
         mon_sel = sel;
         wait_lvl(1'b0, per);
         wait_lvl(1'b1, per);
         hi = 0;
         wait_lvl(1'b0, hi);
         per = hi;
         wait_lvl(1'b1, per);
      end
   endtask : measure
   // hang guard
   always @(posedge clk_sys)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         n_mismatch++;
         final_report();
      end
   end
   // ==========================================
   // main sequence
   initial
   begin
      clk_sys = 1'b0;
      rst = 1'b1;
      osc_input = 1'b0;
      haddr = 32'h0;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'h2;
      hsel = 1'b1;
      hwdata = 32'h0;
      codec_clk_en = 1'b1;
      mon_sel = 2'h0;
      repeat (5) @(negedge clk_sys);
      check(32'({sclk_oe, tx_line_0_oe, tx_line_1_oe}), 32'h0);
      repeat (5) @(posedge clk_sys);
      rst <= 1'b0;
      ahb(1'b0, A_CTRL, 32'h0);
      check(rd, dcsp_pkg::CTRL_RESET);
      check(32'({hresp, hreadyout}), 32'h1);
      ahb(1'b1, A_CTRL, 32'hffff_ffff);
      ahb(1'b0, A_CTRL, 32'h0);
      check(rd, dcsp_pkg::CTRL_WMASK);
      check(32'(user_flag_pin), 32'h1);
      check(32'(sclk_oe), 32'h1);
      // external framing with idle syncs starts nothing; let any running shift drain
      ahb(1'b1, A_CTRL, 32'h0000_0020);
      repeat (300) @(posedge clk_sys);
      ahb(1'b0, A_STAT, 32'h0);
      check(rd, 32'h0);
      check(32'({user_flag_pin, sclk_oe}), 32'h0);
      ahb(1'b1, 32'h0000_000c, 32'hffff_ffff);
      ahb(1'b0, 32'h0000_000c, 32'h0);
      check(rd, 32'h0);
      measure(2'd0);
      check(32'(per), 32'd40);
      // external framing frames, interrupt enabled then masked
      for (int f = 0; f < 2; f++)
      begin
         ctrl = ie_t[f] ? 32'h0000_0038 : 32'h0000_0020;
         ahb(1'b1, A_CTRL, ctrl);
         ahb(1'b1, A_DATA, {16'h0, tx1_t[f], tx0_t[f]});
         ahb(1'b0, A_DATA, 32'h0);
         check({16'h0, rd[15:0]}, {16'h0, tx1_t[f], tx0_t[f]});
         check(32'({tx_line_1_oe, tx_line_0_oe}), 32'h0);
         codec.frame(rx0_t[f], rx1_t[f]);
         repeat (8) @(negedge clk_sys);
         check({16'h0, codec.got_1, codec.got_0}, {16'h0, tx1_t[f], tx0_t[f]});
         check(32'({tx_line_1_oe, tx_line_0_oe}), 32'h0);
         ahb(1'b0, A_DATA, 32'h0);
         check({16'h0, rd[31:16]}, {16'h0, rx1_t[f], rx0_t[f]});
         ahb(1'b0, A_CTRL, 32'h0);
         check(rd, ctrl | 32'h6);
         check(32'(irq), 32'(ie_t[f]));
         ahb(1'b1, A_CTRL, ctrl | 32'h6);
         ahb(1'b0, A_CTRL, 32'h0);
         check(rd, ctrl);
         check(32'(irq), 32'h0);
      end
      // bit clock out, divider 2; internal sync divider 9
      codec_clk_en <= 1'b0;
      ctrl = 32'h0209_0080;
      ahb(1'b1, A_CTRL, ctrl);
      measure(2'd1);
      check(32'(hi), 32'd30);
      check(32'(per), 32'd60);
      measure(2'd2);
      check(32'(hi), 32'd60);
      check(32'(per), 32'd600);
      mon_sel = 2'd3;
      hi = 0;
      wait_lvl(1'b1, hi);
      check(32'(hi < 100), 32'h1);
      ahb(1'b1, A_CTRL, ctrl | 32'h40);
      measure(2'd2);
      check(32'(hi), 32'd480);
      check(32'(per), 32'd600);
      // second reset while the bit clock is driven
      @(posedge clk_sys);
      rst <= 1'b1;
      repeat (2) @(negedge clk_sys);
      check(32'({sclk_oe, tx_line_0_oe, tx_line_1_oe, internal_sync_pulse}), 32'h0);
      @(posedge clk_sys);
      rst <= 1'b0;
      ahb(1'b0, A_CTRL, 32'h0);
      check(rd, dcsp_pkg::CTRL_RESET);
      final_report();
   end
endmodule : dcsp_bench
`default_nettype wire
